// >>> cio_bus_model.sv
`timescale 1ns/10ps

// ****************************************
// memory and peripheral responder
// ****************************************
module cio_bus_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // bus from the port
  input wire logic i_op_request,
  input wire logic i_irq_acknowledge,
  input wire logic i_data_oe,
  input wire logic [12:0] i_addr_lines_low,
  input wire logic [7:0] i_data_lines,
  // test controls
  input wire logic [3:0] i_wait,
  input wire logic [7:0] i_vec,
  // answers
  output logic o_op_acknowledge_n,
  output logic [7:0] o_data_lines,
  output logic [7:0] o_wr_data
);
  logic [3:0] cnt;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_op_acknowledge_n <= 1'b1;
      cnt <= 4'h0;
      o_data_lines <= 8'h00;
      o_wr_data <= 8'h00;
    end else if (!i_op_request) begin
      o_op_acknowledge_n <= 1'b1;
      cnt <= 4'h0;
      o_data_lines <= ~o_data_lines; // released bus inverts its last byte every cycle
    end else if (o_op_acknowledge_n && cnt >= i_wait) begin
      o_op_acknowledge_n <= 1'b0;
      o_data_lines <= i_irq_acknowledge ? i_vec : i_addr_lines_low[7:0] ^ 8'h5A;
    end else if (o_op_acknowledge_n) begin
      cnt <= cnt + 4'h1;
    end else if (i_data_oe) begin
      o_wr_data <= i_data_lines;
    end
  end
endmodule : cio_bus_model

// >>> cio_map.svh
`ifndef CIO_MAP_SVH
`define CIO_MAP_SVH

// command queue depth
`define CIO_FIFO_DEPTH 32

// address widths: full bus and one memory page
`define CIO_ADDR_W 15
`define CIO_PAGE_W 13

// upper status byte field positions
`define CIO_PSW_SENSE 7
`define CIO_PSW_FLAG 6
`define CIO_PSW_INHIBIT 5

// reset value of the stored status bits 6..0
`define CIO_PSW_RST 7'h00

// vector byte bit that selects indirect addressing
`define CIO_VEC_INDIRECT 7

`endif

// >>> cio_pkg.sv
`include "cio_map.svh"

package cio_pkg;

  // operations that the sequencer carries out
  typedef enum logic [3:0] {
    CIO_MEM_RD,
    CIO_MEM_WR,
    CIO_RD_CTRL,
    CIO_RD_DATA,
    CIO_WR_CTRL,
    CIO_WR_DATA,
    CIO_RD_EXT,
    CIO_WR_EXT,
    CIO_LOAD_ST,
    CIO_PRESET_ST,
    CIO_CLEAR_ST,
    CIO_RET_EN
  } cio_op_t;

  // one queued command
  typedef struct packed {
    cio_op_t op;
    logic [`CIO_ADDR_W-1:0] addr;
    logic [7:0] data;
  } cio_cmd_t;

  // interrupt branch target
  typedef struct packed {
    logic indirect;
    logic [`CIO_ADDR_W-1:0] addr;
  } cio_vec_t;

  typedef enum {CIO_ST_IDLE, CIO_ST_REQ, CIO_ST_REL} cio_state_t;

  // what the current bus cycle is for
  typedef enum {CIO_PU_CMD, CIO_PU_VEC, CIO_PU_IND0, CIO_PU_IND1} cio_purp_t;

endpackage : cio_pkg

// >>> cio_port.sv
// Overview of operation
// RULE_01 - a high reset input puts the block into its reset condition
// RULE_02 - pause input low stops new operations; high resumes them
// RULE_03 - flag pin always follows the flag bit of the status word
// RULE_04 - load, preset, clear of status bits apply in the command's last cycle
// RULE_05 - sense pin feeds the status word sense bit directly
// RULE_06 - one-byte I/O drives the data/control line data or control per command
// RULE_07 - one-byte I/O uses memory sequencing, I/O type, non-extended, no address
// RULE_08 - direction line low for reads, high for writes
// RULE_09 - far side trusts qualifiers only while the request is high
// RULE_10 - memory cycles drive memory type and address bits 13 and 14
// RULE_11 - extended read puts port byte on low address, captures data byte
// RULE_12 - extended write drives the data byte while the port byte is out
// RULE_13 - extended cycles mark extended and hold the port byte all request
// RULE_14 - address tristate input high releases the address outputs
// RULE_15 - data tristate input high releases the data bus drivers
// RULE_16 - a positive write strobe pulse goes out in every write cycle
// RULE_17 - one interrupt level; an 8-bit vector picks one of 128 targets
// RULE_18 - vector indirect bit makes the block fetch the target indirectly
// RULE_19 - accepting an interrupt sets the inhibit bit
// RULE_20 - while inhibit is set the request input is ignored
// RULE_21 - inhibit is set by load/preset, cleared by return-enable or clear
// RULE_22 - request stays high until acknowledge low; next waits for release
// RULE_23 - requester gives the vector on the data bus with the acknowledge
// RULE_24 - an all-zero vector gives a direct call to page zero byte zero
// RULE_25 - requester holds its request low until interrupt acknowledge rises
// RULE_26 - run/wait high while running; qualifiers stable for the request

`timescale 1ns/10ps
`include "cio_map.svh"

// ****************************************************************
// command queue
// ****************************************************************
module cio_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `CIO_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  if ((DEPTH < 2) || (DEPTH != (1 << AW))) begin : g_depth_chk
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW+1)'(1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      o_in_ready <= 1'b0;
      o_out_valid <= 1'b0;
    end else begin
      if (push) begin
        wptr <= wptr + AW'(1);
      end
      if (pop) begin
        rptr <= rptr + AW'(1);
      end
      count <= next_count;
      o_in_ready <= (next_count != (AW+1)'(DEPTH));
      o_out_valid <= (next_count != '0);
    end
  end

endmodule : cio_fifo

// ****************************************************************
// processor bus and interrupt port
// ****************************************************************
module cio_port #(
  parameter int FIFO_DEPTH = `CIO_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // command side
  input wire logic i_cmd_valid,
  input cio_pkg::cio_cmd_t i_cmd,
  output logic o_cmd_ready,
  // results
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  output logic o_vec_valid,
  output cio_pkg::cio_vec_t o_vec,
  output logic [7:0] o_status,
  // control inputs
  input wire logic i_pause_n,
  input wire logic i_irq_request_n,
  input wire logic i_op_acknowledge_n,
  input wire logic i_sense,
  input wire logic i_addr_tristate,
  input wire logic i_data_tristate,
  // data bus
  input wire logic [7:0] i_data_lines,
  output logic [7:0] o_data_lines,
  output logic o_data_oe,
  // address and qualifiers
  output logic [`CIO_PAGE_W-1:0] o_addr_lines_low,
  output logic o_extended_io_qual,
  output logic o_data_control,
  output logic o_addr_oe,
  // cycle control
  output logic o_op_request,
  output logic o_mem_io,
  output logic o_read_write,
  output logic o_write_strobe,
  output logic o_irq_acknowledge,
  output logic o_flag,
  output logic o_run_wait
);

  import cio_pkg::*;

  if (FIFO_DEPTH < 2) begin : g_param_chk
    $error("command queue needs at least 2 entries");
  end

  // ****************************************************************
  // declarations
  // ****************************************************************
  cio_state_t state;
  cio_purp_t purp;
  cio_cmd_t q_cmd;
  logic q_valid;
  logic pop;
  logic irq_take;
  logic [6:0] program_status_word;
  logic [7:0] cap;
  logic [7:0] ind_hi;
  logic [`CIO_ADDR_W-1:0] ind_ptr;
  logic [`CIO_ADDR_W-1:0] target;
  logic drv;
  logic fin;
  logic q_bus;
  logic q_wr;
  logic q_io;
  logic q_ext;
  logic q_dsel;

  // ****************************************************************
  // command queue
  // ****************************************************************
  cio_fifo #(
    .WIDTH($bits(cio_cmd_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_in_valid(i_cmd_valid),
    .i_in_data(i_cmd),
    .o_in_ready(o_cmd_ready),
    .o_out_valid(q_valid),
    .o_out_data(q_cmd),
    .i_out_ready(pop)
  );

  // ****************************************************************
  // decode and start conditions
  // ****************************************************************
  assign q_bus = (q_cmd.op inside {CIO_MEM_RD, CIO_MEM_WR, CIO_RD_CTRL,
    CIO_RD_DATA, CIO_WR_CTRL, CIO_WR_DATA, CIO_RD_EXT, CIO_WR_EXT});
  assign q_wr = (q_cmd.op inside {CIO_MEM_WR, CIO_WR_CTRL, CIO_WR_DATA,
    CIO_WR_EXT});
  assign q_io = q_bus && !(q_cmd.op inside {CIO_MEM_RD, CIO_MEM_WR});
  assign q_ext = (q_cmd.op inside {CIO_RD_EXT, CIO_WR_EXT});
  assign q_dsel = (q_cmd.op inside {CIO_RD_DATA, CIO_WR_DATA});

  // interrupt taken between commands only, never while inhibited
  assign irq_take = (state == CIO_ST_IDLE) && i_pause_n && !i_irq_request_n
    && !program_status_word[`CIO_PSW_INHIBIT]; // [RULE_20] [RULE_25]
  assign pop = (state == CIO_ST_IDLE) && q_valid && i_pause_n
    && !irq_take; // [RULE_02]

  // relative vector: signed 7-bit offset, wraps within page zero
  assign target = {2'b00, {6{cap[6]}}, cap[6:0]}; // [RULE_17] [RULE_24]
  assign fin = (state == CIO_ST_REL) && i_op_acknowledge_n;

  // ****************************************************************
  // bus cycle sequencer
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin // [RULE_01]
      state <= CIO_ST_IDLE;
      purp <= CIO_PU_CMD;
      o_op_request <= 1'b0;
      o_mem_io <= 1'b1;
      o_read_write <= 1'b0;
      o_addr_lines_low <= '0;
      o_extended_io_qual <= 1'b0;
      o_data_control <= 1'b0;
      o_data_lines <= 8'h00;
      o_write_strobe <= 1'b0;
      o_irq_acknowledge <= 1'b0;
      drv <= 1'b0;
      cap <= 8'h00;
      ind_hi <= 8'h00;
      ind_ptr <= '0;
    end else begin
      o_write_strobe <= 1'b0; // [RULE_16]
      case (state)
        CIO_ST_IDLE: begin
          if (irq_take) begin
            // vector fetch: I/O read qualified by acknowledge
            purp <= CIO_PU_VEC;
            o_op_request <= 1'b1;
            o_irq_acknowledge <= 1'b1; // [RULE_17]
            o_mem_io <= 1'b0;
            o_read_write <= 1'b0;
            o_addr_lines_low <= '0;
            o_extended_io_qual <= 1'b0;
            o_data_control <= 1'b0;
            state <= CIO_ST_REQ;
          end else if (pop && q_bus) begin
            purp <= CIO_PU_CMD;
            o_op_request <= 1'b1;
            o_mem_io <= !q_io; // [RULE_07] [RULE_10]
            o_read_write <= q_wr; // [RULE_08]
            o_data_lines <= q_cmd.data; // [RULE_12]
            drv <= q_wr;
            o_write_strobe <= q_wr; // [RULE_16]
            if (q_ext) begin
              o_addr_lines_low <= {5'h00, q_cmd.addr[7:0]}; // [RULE_11] [RULE_13]
              o_extended_io_qual <= 1'b1; // [RULE_13]
              o_data_control <= 1'b0;
            end else if (q_io) begin
              o_addr_lines_low <= '0; // [RULE_07]
              o_extended_io_qual <= 1'b0; // [RULE_07]
              o_data_control <= q_dsel; // [RULE_06]
            end else begin
              o_addr_lines_low <= q_cmd.addr[`CIO_PAGE_W-1:0]; // [RULE_10]
              o_extended_io_qual <= q_cmd.addr[13]; // [RULE_10]
              o_data_control <= q_cmd.addr[14]; // [RULE_10]
            end
            state <= CIO_ST_REQ;
          end
        end
        CIO_ST_REQ: begin
          // qualifiers are left untouched until release
          if (!i_op_acknowledge_n) begin // [RULE_22] [RULE_26] [RULE_09]
            o_op_request <= 1'b0;
            drv <= 1'b0;
            cap <= i_data_lines; // [RULE_11] [RULE_23]
            state <= CIO_ST_REL;
          end
        end
        CIO_ST_REL: begin
          if (i_op_acknowledge_n) begin // [RULE_22]
            o_irq_acknowledge <= 1'b0;
            state <= CIO_ST_IDLE;
            case (purp)
              CIO_PU_VEC: begin
                if (cap[`CIO_VEC_INDIRECT]) begin // [RULE_18]
                  ind_ptr <= target;
                  purp <= CIO_PU_IND0;
                  o_op_request <= 1'b1;
                  o_mem_io <= 1'b1;
                  o_read_write <= 1'b0;
                  o_addr_lines_low <= target[`CIO_PAGE_W-1:0];
                  o_extended_io_qual <= target[13];
                  o_data_control <= target[14];
                  state <= CIO_ST_REQ;
                end
              end
              CIO_PU_IND0: begin
                // second pointer byte follows the first
                ind_hi <= cap;
                ind_ptr <= ind_ptr + `CIO_ADDR_W'(1);
                purp <= CIO_PU_IND1;
                o_op_request <= 1'b1;
                o_addr_lines_low <= ind_ptr[`CIO_PAGE_W-1:0] + `CIO_PAGE_W'(1);
                {o_data_control, o_extended_io_qual} <=
                  2'((ind_ptr + `CIO_ADDR_W'(1)) >> `CIO_PAGE_W);
                state <= CIO_ST_REQ; // [RULE_18]
              end
              default: begin
                purp <= CIO_PU_CMD;
              end
            endcase
          end
        end
        default: begin
          state <= CIO_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // upper status byte
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin // [RULE_01]
      program_status_word <= `CIO_PSW_RST;
    end else if (irq_take) begin
      program_status_word[`CIO_PSW_INHIBIT] <= 1'b1; // [RULE_19]
    end else if (pop) begin
      // status commands complete in the cycle they are taken
      case (q_cmd.op)
        CIO_LOAD_ST: program_status_word <= q_cmd.data[6:0]; // [RULE_04] [RULE_21]
        CIO_PRESET_ST: program_status_word <= program_status_word | q_cmd.data[6:0]; // [RULE_04] [RULE_21]
        CIO_CLEAR_ST: program_status_word <= program_status_word & ~q_cmd.data[6:0]; // [RULE_04] [RULE_21]
        CIO_RET_EN: program_status_word[`CIO_PSW_INHIBIT] <= 1'b0; // [RULE_21]
        default: program_status_word <= program_status_word;
      endcase
    end
  end

  // ****************************************************************
  // pin enables and indicators
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin // [RULE_01]
      o_addr_oe <= 1'b0;
      o_data_oe <= 1'b0;
      o_flag <= 1'b0;
      o_status <= 8'h00;
      o_run_wait <= 1'b0;
    end else begin
      o_addr_oe <= !i_addr_tristate; // [RULE_14]
      o_data_oe <= drv && !i_data_tristate; // [RULE_15] [RULE_12]
      o_flag <= program_status_word[`CIO_PSW_FLAG]; // [RULE_03]
      o_status <= {i_sense, program_status_word}; // [RULE_05]
      o_run_wait <= i_pause_n; // [RULE_26] [RULE_02]
    end
  end

  // ****************************************************************
  // results
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin // [RULE_01]
      o_rd_valid <= 1'b0;
      o_rd_data <= 8'h00;
      o_vec_valid <= 1'b0;
      o_vec <= '0;
    end else begin
      o_rd_valid <= fin && (purp == CIO_PU_CMD) && !o_read_write; // [RULE_11]
      o_rd_data <= cap;
      o_vec_valid <= fin && (((purp == CIO_PU_VEC) && !cap[`CIO_VEC_INDIRECT])
        || (purp == CIO_PU_IND1)); // [RULE_17] [RULE_24]
      if (purp == CIO_PU_IND1) begin
        o_vec <= {1'b1, ind_hi[6:0], cap}; // [RULE_18]
      end else begin
        o_vec <= {1'b0, target}; // [RULE_24]
      end
    end
  end

endmodule : cio_port

// >>> cio_port_assertions.sv
`timescale 1ns/10ps
`include "cio_map.svh"

// ****************************************
// bus and interrupt port checker
// ****************************************
module cio_port_assertions #(
  parameter int FIFO_DEPTH = `CIO_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // control inputs
  input wire logic i_pause_n,
  input wire logic i_op_acknowledge_n,
  input wire logic i_sense,
  input wire logic i_addr_tristate,
  input wire logic i_data_tristate,
  // observed outputs
  input wire logic [`CIO_PAGE_W-1:0] o_addr_lines_low,
  input wire logic o_extended_io_qual,
  input wire logic o_data_control,
  input wire logic o_addr_oe,
  input wire logic o_data_oe,
  input wire logic o_op_request,
  input wire logic o_mem_io,
  input wire logic o_read_write,
  input wire logic o_write_strobe,
  input wire logic o_irq_acknowledge,
  input wire logic [7:0] o_status,
  input wire logic o_run_wait
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  a_req_held: assert property (o_op_request && i_op_acknowledge_n |=> o_op_request)
    else $error("request dropped before acknowledge");
  a_req_drop: assert property (o_op_request && !i_op_acknowledge_n |=> !o_op_request)
    else $error("request kept after acknowledge");
  a_qual_stable: assert property (o_op_request && $past(o_op_request) |->
    $stable({o_mem_io, o_read_write, o_addr_lines_low, o_extended_io_qual, o_data_control}))
    else $error("qualifiers moved during request");
  a_strobe_write: assert property ($rose(o_op_request) |-> o_write_strobe == o_read_write)
    else $error("write strobe does not match cycle");
  a_strobe_only: assert property (o_write_strobe |-> o_op_request && o_read_write)
    else $error("write strobe outside a write");
  a_io_addr_zero: assert property (
    o_op_request && !o_mem_io && !o_extended_io_qual |-> o_addr_lines_low == 13'h0000)
    else $error("one-byte cycle shows an address");
  a_ext_port: assert property (
    o_op_request && !o_mem_io && o_extended_io_qual |-> o_addr_lines_low[12:8] == 5'h00)
    else $error("extended cycle address beyond low byte");
  a_addr_release: assert property (!$past(i_rst) |-> o_addr_oe == !$past(i_addr_tristate))
    else $error("address drive does not follow tristate");
  a_data_release: assert property (i_data_tristate |=> !o_data_oe)
    else $error("data driven while tristated");
  a_sense_follow: assert property (!$past(i_rst) |-> o_status[7] == $past(i_sense))
    else $error("sense bit does not follow pin");
  a_run_follow: assert property (!$past(i_rst) |-> o_run_wait == $past(i_pause_n))
    else $error("run indicator does not follow pause");
  a_inhibit_set: assert property ($rose(o_irq_acknowledge) |-> ##[0:2] o_status[5])
    else $error("inhibit not set on interrupt");
endmodule : cio_port_assertions

bind cio_port cio_port_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.i_mclk, .i_rst,
  .i_pause_n, .i_op_acknowledge_n, .i_sense, .i_addr_tristate, .i_data_tristate,
  .o_addr_lines_low, .o_extended_io_qual, .o_data_control, .o_addr_oe, .o_data_oe,
  .o_op_request, .o_mem_io, .o_read_write, .o_write_strobe, .o_irq_acknowledge,
  .o_status, .o_run_wait);

// >>> cio_port_test.sv
`timescale 1ns/10ps
`include "cio_map.svh"

// ****************************************
// bus and interrupt port bench
// ****************************************
module cio_port_test;
  import cio_pkg::*;
  typedef struct packed {
    cio_op_t op;
    logic [14:0] addr;
    logic [7:0] data;
    logic [3:0] q;
    logic [12:0] low;
    logic [7:0] rd;
  } cio_row_t;
  logic i_mclk, i_rst, i_cmd_valid, i_pause_n, i_irq_request_n, i_sense;
  logic i_addr_tristate, i_data_tristate, i_op_acknowledge_n;
  logic o_cmd_ready, o_rd_valid, o_vec_valid, o_data_oe, o_extended_io_qual, o_data_control;
  logic o_addr_oe, o_op_request, o_mem_io, o_read_write, o_write_strobe, o_irq_acknowledge;
  logic o_flag, o_run_wait;
  logic [7:0] o_rd_data, o_status, i_data_lines, o_data_lines, vec, wr_data;
  logic [12:0] o_addr_lines_low;
  logic [3:0] slow;
  cio_cmd_t i_cmd;
  cio_vec_t o_vec;
  int num_errors = 0;
  int tests_run = 0;
  int i, n;
  // q is {mem_io, read_write, extended, data_control}
  cio_row_t rows [8] = '{'{CIO_MEM_RD, 15'h6ABC, 8'h00, 4'hB, 13'h0ABC, 8'hE6},
    '{CIO_MEM_WR, 15'h1234, 8'h3C, 4'hC, 13'h1234, 8'h00},
    '{CIO_RD_CTRL, 15'h7FFF, 8'h00, 4'h0, 13'h0000, 8'h5A},
    '{CIO_RD_DATA, 15'h7FFF, 8'h00, 4'h1, 13'h0000, 8'h5A},
    '{CIO_WR_CTRL, 15'h7FFF, 8'h81, 4'h4, 13'h0000, 8'h00},
    '{CIO_WR_DATA, 15'h7FFF, 8'h7E, 4'h5, 13'h0000, 8'h00},
    '{CIO_RD_EXT, 15'h7FC3, 8'h00, 4'h2, 13'h00C3, 8'h99},
    '{CIO_WR_EXT, 15'h7F42, 8'hE1, 4'h6, 13'h0042, 8'h00}};
  cio_op_t sops [3] = '{CIO_LOAD_ST, CIO_PRESET_ST, CIO_CLEAR_ST};
  logic [7:0] sdat [3] = '{8'h40, 8'h20, 8'h40};
  logic [2:0] sexp [3] = '{3'h6, 3'h7, 3'h1};
  logic [7:0] vecs [4] = '{8'h3F, 8'h00, 8'h40, 8'h85};
  logic [15:0] vexp [4] = '{16'h003F, 16'h0000, 16'h1FC0, 16'hDF5C};

  cio_port #(.FIFO_DEPTH(4)) dut (.i_mclk, .i_rst, .i_cmd_valid, .i_cmd, .o_cmd_ready,
    .o_rd_valid, .o_rd_data, .o_vec_valid, .o_vec, .o_status, .i_pause_n, .i_irq_request_n,
    .i_op_acknowledge_n, .i_sense, .i_addr_tristate, .i_data_tristate, .i_data_lines,
    .o_data_lines, .o_data_oe, .o_addr_lines_low, .o_extended_io_qual, .o_data_control,
    .o_addr_oe, .o_op_request, .o_mem_io, .o_read_write, .o_write_strobe,
    .o_irq_acknowledge, .o_flag, .o_run_wait);
  cio_bus_model far (.i_mclk, .i_rst, .i_op_request(o_op_request),
    .i_irq_acknowledge(o_irq_acknowledge), .i_data_oe(o_data_oe),
    .i_addr_lines_low(o_addr_lines_low), .i_data_lines(o_data_lines), .i_wait(slow),
    .i_vec(vec), .o_op_acknowledge_n(i_op_acknowledge_n), .o_data_lines(i_data_lines),
    .o_wr_data(wr_data));

  task automatic step();
    @(posedge i_mclk);
    #1;
  endtask : step

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic push(input cio_op_t op, input logic [14:0] a, input logic [7:0] d);
    step();
    i_cmd_valid = 1'b1;
    i_cmd = {op, a, d};
    while (o_cmd_ready !== 1'b1) step();
    step();
    i_cmd_valid = 1'b0;
  endtask : push

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  initial begin
    repeat (20000) @(posedge i_mclk);
    num_errors++;
    wrap_up();
  end

  initial begin
    {i_rst, i_pause_n, i_irq_request_n} = 3'h7;
    {i_cmd_valid, i_sense, i_addr_tristate, i_data_tristate} = 4'h0;
    i_cmd = '0;
    slow = 4'h0;
    vec = 8'h00;
    repeat (20) step();
    i_rst = 1'b0;
    step();
    step();
    check({o_cmd_ready, o_mem_io, o_op_request, o_status[6:5]}, 5'h18);
    for (i = 0; i < 8; i++) begin
      push(rows[i].op, rows[i].addr, rows[i].data);
      while (o_op_request !== 1'b1) step();
      check({o_mem_io, o_read_write, o_extended_io_qual, o_data_control}, rows[i].q);
      check(o_write_strobe, rows[i].q[2]);
      check(o_addr_lines_low, rows[i].low);
      while (o_op_request === 1'b1) step();
      if (rows[i].q[2]) check(wr_data, rows[i].data);
      else begin
        while (o_rd_valid !== 1'b1) step();
        check(o_rd_data, rows[i].rd);
      end
    end
    for (i = 0; i < 3; i++) begin
      push(sops[i], 15'h0000, sdat[i]);
      repeat (6) step();
      check({o_flag, o_status[6:5]}, sexp[i]);
    end
    i_sense = 1'b1;
    push(CIO_PRESET_ST, 15'h0000, 8'h20);
    i_irq_request_n = 1'b0;
    repeat (10) step();
    check({o_irq_acknowledge, o_status[7]}, 2'h1);
    for (i = 0; i < 4; i++) begin
      vec = vecs[i];
      i_irq_request_n = 1'b0;
      push(i ? CIO_CLEAR_ST : CIO_RET_EN, 15'h0000, 8'h20);
      while (o_irq_acknowledge !== 1'b1) step();
      i_irq_request_n = 1'b1;
      while (o_vec_valid !== 1'b1) step();
      check(o_vec, vexp[i]);
      step();
      check(o_status[5], 1'b1);
    end
    i_pause_n = 1'b0;
    slow = 4'h3;
    step();
    step();
    n = 0;
    i_cmd = {CIO_MEM_RD, 15'h0011, 8'h00};
    i_cmd_valid = 1'b1;
    repeat (8) begin
      if (o_cmd_ready === 1'b1) n++;
      step();
    end
    i_cmd_valid = 1'b0;
    check({n[3:0], o_op_request, o_run_wait}, 6'h10);
    i_pause_n = 1'b1;
    n = 0;
    repeat (100) begin
      step();
      if (o_rd_valid === 1'b1) begin
        n++;
        check(o_rd_data, 8'h4B);
      end
    end
    check(n[3:0], 4'h4);
    {i_addr_tristate, i_data_tristate} = 2'h3;
    push(CIO_MEM_WR, 15'h0020, 8'h99);
    while (o_op_request !== 1'b1) step();
    step();
    check({o_addr_oe, o_data_oe}, 2'h0);
    while (o_op_request === 1'b1) step();
    {i_addr_tristate, i_data_tristate} = 2'h0;
    push(CIO_LOAD_ST, 15'h0000, 8'h40);
    repeat (6) step();
    i_rst = 1'b1;
    step();
    step();
    i_rst = 1'b0;
    step();
    check({o_flag, o_status[6:5], o_mem_io, o_op_request}, 5'h02);
    wrap_up();
  end
endmodule : cio_port_test
